/* verilog/wkdet_top.sv */
`timescale 1ns/10ps
// Overview of operation
// RL1 - Three independent high-voltage wake inputs
// RL2 - Both rising and falling edges signal
// RL3 - Interrupt in normal/stop, wake in sleep/failsafe
// RL4 - Static continuous or cyclic windowed detection
// RL5 - Cyclic sense uses timer one or two
// RL6 - Static filter is 16 or 64 us
// RL7 - Wake only if level holds whole filter
// RL8 - Per-pin wake enable bits
// RL9 - Latched per-pin wake source flags, always readable
// RL10 - Pin levels readable in normal and stop
// RL11 - Cyclic sense reports last sampled level
// RL12 - Fail outputs as wakes: 16us, aux status
// RL13 - Software selects pull-up or pull-down sources
// RL14 - Bias none, down, up, or automatic
// RL15 - Filter codes: 16us, 64us, sense_timer_one, sense_timer_two
// RL16 - Inputs synchronized, filter counted on clock
// RL17 - Wake flags stay until software clears
module wkdet_top
  import wkdet_pkg::*;
#(
  parameter int SHORT_CYC = wkdet_pkg::SHORT_FILTER_CYC,
  parameter int LONG_CYC = wkdet_pkg::LONG_FILTER_CYC
) (
  input wire logic clk, // 100 MHz clock
  input wire logic rst, // Synchronous reset, high
  input wire logic [1:0] chip_mode, // Operating mode of the chip
  input wire logic [2:0] wake_pin_n, // Raw wake pin levels
  input wire logic [1:0] fail_out_pin, // Fail output pin levels
  input wire logic [1:0] fail_out_wake_en, // Fail output used as wake
  input wire logic [2:0] wake_enable_control, // Per-pin wake enables
  input wire logic [5:0] detect_filter_select, // 2 bits per pin
  input wire logic [5:0] input_bias_select, // 2 bits per pin
  input wire logic sense_timer_one, // Timer one on-window
  input wire logic sense_timer_two, // Timer two on-window
  input wire logic [2:0] wake_source_clear, // Clear pulses
  input wire logic [1:0] aux_wake_source_clear, // Clear pulses
  output logic [2:0] wake_source_status, // Latched wake flags
  output logic [1:0] aux_wake_source_status, // Latched aux flags
  output logic [2:0] wake_pin_level_status, // Level readback
  output logic [2:0] pull_up_en, // Pull-up source on
  output logic [2:0] pull_down_en, // Pull-down source on
  output logic wake_irq, // One-cycle interrupt pulse
  output logic wake_up // One-cycle wake request pulse
);
  localparam int NCH = NUM_WAKE + NUM_AUX;

  // Filter counts must fit the counter and be at least one cycle
  if (SHORT_CYC < 1 || LONG_CYC < 1 || SHORT_CYC >= (1 << CNT_W) ||
      LONG_CYC >= (1 << CNT_W)) begin : g_bad_cnt
    $error("wkdet_top: filter counts out of range");
  end

  typedef struct packed {
    logic [NCH-1:0] sync1;
    logic [NCH-1:0] sync2;
    logic [NCH-1:0] stable;
    logic [NCH-1:0][CNT_W-1:0] cnt;
    logic [NCH-1:0] win_d;
    logic [2:0] level;
    logic [2:0] flag;
    logic [1:0] aux_flag;
    logic [2:0] pu;
    logic [2:0] pd;
    logic irq;
    logic wake;
  } wkdet_state_t;

  wkdet_state_t s;
  wkdet_state_t next_s;

  // ==========================================================
  // Per-channel filter parameters
  logic [NCH-1:0] raw_in;
  logic [NCH-1:0] win;
  logic [NCH-1:0] cyclic;
  logic [NCH-1:0][CNT_W-1:0] limit;

  assign raw_in = {fail_out_pin, wake_pin_n}; // [RL1] [RL12]

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      if (g < NUM_WAKE) begin : g_wk
        logic [1:0] fsel;
        assign fsel = detect_filter_select[2*g +: 2];
        always_comb begin
          case (fsel) // [RL15]
            FLT_STATIC_SHORT: win[g] = 1'b1; // [RL4]
            FLT_STATIC_LONG: win[g] = 1'b1;
            FLT_CYCLIC_T1: win[g] = sense_timer_one; // [RL5]
            FLT_CYCLIC_T2: win[g] = sense_timer_two;
            default: win[g] = 1'b1;
          endcase
        end
        assign cyclic[g] = fsel[1];
        // [RL6]
        assign limit[g] = (fsel == FLT_STATIC_LONG) ?
          CNT_W'(LONG_CYC) : CNT_W'(SHORT_CYC);
      end else begin : g_aux
        assign win[g] = fail_out_wake_en[g-NUM_WAKE];
        assign cyclic[g] = 1'b0;
        assign limit[g] = CNT_W'(SHORT_CYC); // [RL12]
      end
    end
  endgenerate

  // ==========================================================
  // Next-state logic
  always_comb begin
    logic [NCH-1:0] edge_ok;
    edge_ok = '0;
    next_s = s;
    next_s.sync1 = raw_in; // [RL16]
    next_s.sync2 = s.sync1;
    next_s.win_d = win;
    for (int i = 0; i < NCH; i++) begin
      if (!win[i]) begin
        next_s.cnt[i] = '0;
        // Resume from the present level when the window reopens
        if (!s.win_d[i]) begin
          next_s.stable[i] = s.sync2[i];
        end
      end else if (s.sync2[i] == s.stable[i]) begin
        next_s.cnt[i] = '0; // [RL7]
      end else if (s.cnt[i] + CNT_W'(1) >= limit[i]) begin
        next_s.cnt[i] = '0;
        next_s.stable[i] = s.sync2[i];
        edge_ok[i] = 1'b1; // [RL2] [RL7]
      end else begin
        next_s.cnt[i] = s.cnt[i] + CNT_W'(1); // [RL16]
      end
    end
    for (int i = 0; i < NUM_WAKE; i++) begin
      if (cyclic[i]) begin
        if (win[i]) begin
          next_s.level[i] = s.sync2[i]; // [RL11]
        end
      end else begin
        next_s.level[i] = s.sync2[i]; // [RL10]
      end
      // Set wins over a same-cycle clear
      if (wake_source_clear[i]) begin
        next_s.flag[i] = 1'b0; // [RL17]
      end
      if (edge_ok[i] && wake_enable_control[i]) begin
        next_s.flag[i] = 1'b1; // [RL8] [RL9]
      end
      case (input_bias_select[2*i +: 2]) // [RL13] [RL14]
        BIAS_NONE: begin
          next_s.pu[i] = 1'b0;
          next_s.pd[i] = 1'b0;
        end
        BIAS_DOWN: begin
          next_s.pu[i] = 1'b0;
          next_s.pd[i] = 1'b1;
        end
        BIAS_UP: begin
          next_s.pu[i] = 1'b1;
          next_s.pd[i] = 1'b0;
        end
        BIAS_AUTO: begin
          next_s.pu[i] = s.sync2[i];
          next_s.pd[i] = !s.sync2[i];
        end
        default: begin
          next_s.pu[i] = 1'b0;
          next_s.pd[i] = 1'b0;
        end
      endcase
    end
    for (int j = 0; j < NUM_AUX; j++) begin
      if (aux_wake_source_clear[j]) begin
        next_s.aux_flag[j] = 1'b0;
      end
      if (edge_ok[NUM_WAKE+j]) begin
        next_s.aux_flag[j] = 1'b1; // [RL12]
      end
    end
    next_s.irq = 1'b0;
    next_s.wake = 1'b0;
    if ((|(edge_ok[NUM_WAKE-1:0] & wake_enable_control)) ||
        (|edge_ok[NCH-1:NUM_WAKE])) begin
      if (chip_mode == MODE_NORMAL || chip_mode == MODE_STOP) begin
        next_s.irq = 1'b1; // [RL3]
      end else begin
        next_s.wake = 1'b1; // [RL3]
      end
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.flag <= WAKE_ENABLE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign wake_source_status = s.flag;
  assign aux_wake_source_status = s.aux_flag;
  assign wake_pin_level_status = s.level;
  assign pull_up_en = s.pu;
  assign pull_down_en = s.pd;
  assign wake_irq = s.irq;
  assign wake_up = s.wake;
endmodule // wkdet_top

/* pkg/wkdet_pkg.sv */
package wkdet_pkg;
  // ==========================================================
  // Counts and sizes
  localparam int NUM_WAKE = 3;
  localparam int NUM_AUX = 2;
  localparam int CLK_MHZ = 100;
  localparam int SHORT_FILTER_US = 16;
  localparam int LONG_FILTER_US = 64;
  localparam int SHORT_FILTER_CYC = SHORT_FILTER_US * CLK_MHZ;
  localparam int LONG_FILTER_CYC = LONG_FILTER_US * CLK_MHZ;
  localparam int CNT_W = 13;
  // ==========================================================
  // Chip operating modes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_STOP = 2'h1;
  localparam logic [1:0] MODE_SLEEP = 2'h2;
  localparam logic [1:0] MODE_FAILSAFE = 2'h3;
  // ==========================================================
  // Detect filter select codes
  localparam logic [1:0] FLT_STATIC_SHORT = 2'h0;
  localparam logic [1:0] FLT_STATIC_LONG = 2'h1;
  localparam logic [1:0] FLT_CYCLIC_T1 = 2'h2;
  localparam logic [1:0] FLT_CYCLIC_T2 = 2'h3;
  // ==========================================================
  // Input bias select codes
  localparam logic [1:0] BIAS_NONE = 2'h0;
  localparam logic [1:0] BIAS_DOWN = 2'h1;
  localparam logic [1:0] BIAS_UP = 2'h2;
  localparam logic [1:0] BIAS_AUTO = 2'h3;
  // ==========================================================
  // Reset values
  localparam logic [2:0] WAKE_ENABLE_RST = 3'h0;
  localparam logic [1:0] BIAS_RST = BIAS_NONE;
endpackage

/* bench/wkdet_props.sv */
`timescale 1ns/10ps
module wkdet_props
  import wkdet_pkg::*;
#(parameter int SHORT_CYC = 4) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [1:0] chip_mode,
  input wire logic [2:0] wake_pin_n,
  input wire logic [2:0] wake_enable_control,
  input wire logic [5:0] detect_filter_select,
  input wire logic [5:0] input_bias_select,
  input wire logic [2:0] wake_source_clear,
  input wire logic [2:0] wake_source_status,
  input wire logic [2:0] wake_pin_level_status,
  input wire logic [2:0] pull_up_en,
  input wire logic [2:0] pull_down_en,
  input wire logic wake_irq,
  input wire logic wake_up
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // Cycles pin one has held its level
  logic [CNT_W-1:0] st0;
  logic p0;
  always_ff @(posedge clk) begin
    p0 <= wake_pin_n[0];
    if (rst || wake_pin_n[0] != p0) st0 <= '0;
    else if (st0 != '1) st0 <= st0 + 1'b1;
  end
  sequence s_flag_rise;
    (wake_source_status & ~$past(wake_source_status)) != 3'h0;
  endsequence
  property p_excl; !(wake_irq && wake_up); endproperty
  a_excl: assert property (p_excl) else $error("irq and wake");
  property p_irq_mode; wake_irq |-> !$past(chip_mode[1]); endproperty
  a_irq_mode: assert property (p_irq_mode) else $error("irq mode");
  property p_wake_mode; wake_up |-> $past(chip_mode[1]); endproperty
  a_wake_mode: assert property (p_wake_mode) else $error("wake mode");
  property p_pulse; wake_irq || wake_up |=> !wake_irq && !wake_up; endproperty
  a_pulse: assert property (p_pulse) else $error("pulse long");
  property p_sticky;
    1 |=> ($past(wake_source_status & ~wake_source_clear) &
      ~wake_source_status) == 3'h0;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_flag_sig; s_flag_rise |-> wake_irq || wake_up; endproperty
  a_flag_sig: assert property (p_flag_sig) else $error("no signal");
  property p_filter; $rose(wake_source_status[0]) |-> st0 >= SHORT_CYC;
  endproperty
  a_filter: assert property (p_filter) else $error("filter short");
  property p_enable;
    $rose(wake_source_status[0]) |-> $past(wake_enable_control[0]);
  endproperty
  a_enable: assert property (p_enable) else $error("disabled pin");
  property p_level;
    !chip_mode[1] && !detect_filter_select[1] && st0 >= 5 |->
      wake_pin_level_status[0] == $past(wake_pin_n[0], 3);
  endproperty
  a_level: assert property (p_level) else $error("level");
  property p_bias;
    !$past(rst) && $stable(input_bias_select[5:4]) &&
      input_bias_select[5:4] != BIAS_AUTO |->
      {pull_up_en[2], pull_down_en[2]} == {input_bias_select[5:4] ==
      BIAS_UP, input_bias_select[5:4] == BIAS_DOWN};
  endproperty
  a_bias: assert property (p_bias) else $error("bias");
endmodule // wkdet_props
bind wkdet_top wkdet_props #(.SHORT_CYC(SHORT_CYC)) wkdet_props_inst (.clk,
  .rst, .chip_mode, .wake_pin_n, .wake_enable_control, .detect_filter_select,
  .input_bias_select, .wake_source_clear, .wake_source_status,
  .wake_pin_level_status, .pull_up_en, .pull_down_en, .wake_irq, .wake_up);

/* bench/wkdet_sw.sv */
`timescale 1ns/10ps
// Switches on the wake and fail-output pins, driven hard
module wkdet_sw (
  input wire logic [4:0] req, // Requested switch levels
  output logic [4:0] pin // Pin levels
);
  assign pin = req;
endmodule // wkdet_sw

/* bench/tb_wkdet_top.sv */
`timescale 1ns/10ps
module tb_wkdet_top;
  import wkdet_pkg::*;
  localparam int SC = 4;
  localparam int LC = 8;
  logic clk = 0, rst = 1, t1 = 0, t2 = 0;
  logic [1:0] mode = MODE_NORMAL, fo_en = 0, ac = 0, aux;
  logic [2:0] en = 3'h5, clr = 0, sts, lvl, pu, pd;
  logic [4:0] pr = 0, pin, st;
  logic [5:0] flt = 0, bias = 0;
  logic irq, wk;
  logic [31:0] seed = 32'h13;
  int n_fail = 0, num_checks = 0, n_irq = 0, n_wk = 0, k;
  assign st = {aux, sts};
  wkdet_sw wkdet_sw_inst (.req(pr), .pin(pin));
  wkdet_top #(.SHORT_CYC(SC), .LONG_CYC(LC)) wkdet_top_inst (.clk, .rst,
    .chip_mode(mode), .wake_pin_n(pin[2:0]), .fail_out_pin(pin[4:3]),
    .fail_out_wake_en(fo_en), .wake_enable_control(en),
    .detect_filter_select(flt), .input_bias_select(bias),
    .sense_timer_one(t1), .sense_timer_two(t2), .wake_source_clear(clr),
    .aux_wake_source_clear(ac), .wake_source_status(sts),
    .aux_wake_source_status(aux), .wake_pin_level_status(lvl),
    .pull_up_en(pu), .pull_down_en(pd), .wake_irq(irq), .wake_up(wk));
  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_irq += (irq === 1'b1);
    n_wk += (wk === 1'b1);
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [7:0] eb(input logic [1:0] c, input logic l);
    return {6'h0, c == BIAS_UP || (c == BIAS_AUTO && l),
      c == BIAS_DOWN || (c == BIAS_AUTO && !l)};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d fails %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt(input int b, input int lim);
    int i;
    for (i = 0; i < lim && st[b] !== 1'b1; i++) cyc(1);
    chk(st[b], 1);
    if (i == lim) finish_test();
  endtask
  task automatic clear();
    clr = 3'h7;
    cyc(1);
    clr = 0;
    cyc(1);
  endtask
  initial begin
    cyc(10);
    rst = 0;
    pr[0] = 1;
    cyc(SC - 1);
    chk(st[0], 0);
    wt(0, 8);
    cyc(2);
    chk(8'(n_irq), 1);
    chk(lvl[0], 1);
    clear();
    chk(st[0], 0);
    seed = xs(seed);
    pr[0] = 0;
    cyc(1 + seed % (SC - 1));
    pr[0] = 1;
    cyc(SC + 6);
    chk(st[0], 0);
    pr[0] = 0;
    wt(0, SC + 6);
    clear();
    flt[1:0] = FLT_STATIC_LONG;
    pr[0] = 1;
    cyc(SC + 3);
    chk(st[0], 0);
    wt(0, LC);
    pr[1] = 1;
    cyc(LC + 6);
    chk(st[1], 0);
    chk(lvl[1], 1);
    en[1] = 1;
    flt[3:2] = FLT_CYCLIC_T1;
    pr[1] = 0;
    cyc(SC + 6);
    chk(lvl[1], 1);
    t1 = 1;
    cyc(SC + 6);
    chk(st[1], 0);
    chk(lvl[1], 0);
    pr[1] = 1;
    wt(1, SC + 6);
    clear();
    flt[3:2] = FLT_CYCLIC_T2;
    t2 = 1;
    cyc(SC + 6);
    pr[1] = 0;
    wt(1, SC + 6);
    cyc(2);
    k = n_irq;
    mode = MODE_SLEEP;
    pr[2] = 1;
    wt(2, SC + 6);
    cyc(2);
    chk(8'(n_wk), 1);
    chk(8'(n_irq), 8'(k));
    mode = MODE_FAILSAFE;
    fo_en = 2'h1;
    pr[3] = 1;
    wt(3, SC + 6);
    cyc(2);
    chk(8'(n_wk), 2);
    ac = 2'h1;
    cyc(1);
    ac = 2'h0;
    cyc(1);
    chk(st[3], 0);
    for (int c = 0; c < 5; c++) begin
      bias[5:4] = 2'(c);
      pr[2] = (c < 4);
      cyc(6);
      chk({6'h0, pu[2], pd[2]}, eb(bias[5:4], pr[2]));
    end
    finish_test();
  end
endmodule // tb_wkdet_top
